// ===== inc/btc_params.svh
// constants for the branch target and condition unit
`ifndef BTC_PARAMS_SVH
`define BTC_PARAMS_SVH

// ----------------------------------------------------------------
// instruction fields (bit 0 of the word is the lsb here)
// ----------------------------------------------------------------
`define BTC_LK_BIT       0
`define BTC_AA_BIT       1
`define BTC_BO_HI        25
`define BTC_BO_LO        21
`define BTC_BI_HI        20
`define BTC_BI_LO        16
`define BTC_BH_HI        12
`define BTC_BH_LO        11
`define BTC_LI_HI        25
`define BTC_LI_LO        2
`define BTC_BD_HI        15
`define BTC_BD_LO        2

// ----------------------------------------------------------------
// branch options field bits
// ----------------------------------------------------------------
`define BTC_BO_NOCOND    4
`define BTC_BO_CRVAL     3
`define BTC_BO_NODEC     2
`define BTC_BO_ZERO      1
`define BTC_BO_T         0
`define BTC_BO_A_NODEC   1

// ----------------------------------------------------------------
// addressing constants
// ----------------------------------------------------------------
`define BTC_INSN_BYTES   64'h0000_0000_0000_0004
`define BTC_CR_MSB       5'h1f
`define BTC_NIA_BO       5'h14
`define BTC_NIA_BI       5'h1f

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define BTC_REG_CTRL     8'h00
`define BTC_REG_LR_LO    8'h04
`define BTC_REG_LR_HI    8'h08
`define BTC_REG_CTR_LO   8'h0c
`define BTC_REG_CTR_HI   8'h10
`define BTC_REG_CR       8'h14
`define BTC_REG_STAT     8'h18
`define BTC_CTRL_MODE32  0
`define BTC_CTRL_STACK   1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define BTC_RST_LR       64'h0000_0000_0000_0000
`define BTC_RST_CTR      64'h0000_0000_0000_0000
`define BTC_RST_CR       32'h0000_0000

`endif

// ===== inc/btc_pkg.sv
// types for the branch target and condition unit
package btc_pkg;

  // ----------------------------------------------------------------
  // branch kinds as predecoded by fetch
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BTC_K_IMM  = 2'b00,
    BTC_K_CIMM = 2'b01,
    BTC_K_LNK  = 2'b10,
    BTC_K_CNT  = 2'b11
  } btc_kind_t;

  // ----------------------------------------------------------------
  // target usage hint
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BTC_TH_NONE   = 3'b000,
    BTC_TH_RETURN = 3'b001,
    BTC_TH_REPEAT = 3'b010,
    BTC_TH_UNPRED = 3'b011,
    BTC_TH_RSVD   = 3'b100
  } btc_thint_t;

  // ----------------------------------------------------------------
  // whole state of the unit
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        mode32;
    logic        stack_en;
    logic [63:0] lr;
    logic [63:0] ctr;
    logic [31:0] cr;
    logic [31:0] rd_data;
    logic        redir;
    logic [63:0] next_addr;
    logic        taken;
    logic [1:0]  thint;
    btc_thint_t  tgt_hint;
    logic        lr_push;
  } btc_state_t;

endpackage : btc_pkg

// ===== hw/btc_ctr_test.sv
// count test: zero detect over the tested slice of the count
`timescale 1ns/1ps
module btc_ctr_test #(
  parameter int W    = 64,
  parameter int HALF = 32
) (
  // value and mode
  input  wire logic [W-1:0] i_value,
  input  wire logic         i_mode32,
  // result
  output logic              o_zero
);

  // ----------------------------------------------------------------
  // narrow mode tests only the low half
  // ----------------------------------------------------------------
  always_comb begin
    if (i_mode32) begin
      o_zero = (i_value[HALF-1:0] == '0);
    end else begin
      o_zero = (i_value == '0);
    end
  end

endmodule : btc_ctr_test

// ===== hw/btc_unit.sv
// branch target formation and branch condition resolution
// Notes on behaviour
// - unconditional absolute: target is sign-extended long displacement with two zeros
// - conditional absolute taken: target is sign-extended short displacement, two zeros
// - absolute select bit one means absolute, zero means relative target
// - link update bit one writes following instruction address into link register
// - taken branch to link fetches link register with low two bits cleared
// - taken branch to count fetches count register with low two bits cleared
// - link or count form with link bit updates link even when not taken
// - count test covers low 32 bits in 32-bit mode, all 64 otherwise
// - a requested decrement always acts on the full 64-bit count
// - decrementing codes 0000z/0001z/0100z/0101z branch on count zero test and condition bit value
// - codes 001xx/011xx leave count, test condition bit; 1z1zz always branch
// - codes 1a00t/1a01t decrement and test count only, ignoring condition
// - don't-care bits of branch options never affect the outcome
// - taken hint pair: none, reserved, likely not taken, likely taken
// - target hint 00: return for link form, repeating target for count form
// - target hint 01 repeat/reserved, 10 reserved, 11 unpredictable
// - target hint gives no taken likelihood; kept apart from taken hint
// - 5-bit selector picks one of 32 condition register bits
// - link stack push skips the branch-and-link 20,31 next-address form
// - in 32-bit mode upper 32 target bits are cleared last
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "btc_params.svh"
module btc_unit (
  // clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_sys_rst,
  // branch request from fetch
  input  wire logic              i_br_valid,
  input  wire btc_pkg::btc_kind_t i_br_kind,
  input  wire logic [31:0]       i_br_instr,
  input  wire logic [63:0]       i_br_cia,
  // register port
  input  wire logic [7:0]        i_reg_addr,
  input  wire logic [31:0]       i_reg_wdata,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  output logic [31:0]            o_reg_rdata,
  // branch outcome to fetch
  output logic                   o_redirect_valid,
  output logic [63:0]            o_next_addr,
  output logic                   o_taken,
  output logic [1:0]             o_taken_hint,
  output btc_pkg::btc_thint_t    o_target_hint,
  output logic                   o_lr_push
);
  import btc_pkg::*;

  btc_state_t st;
  btc_state_t nx;

  // ----------------------------------------------------------------
  // instruction fields
  // ----------------------------------------------------------------
  logic [4:0]  bo;
  logic [4:0]  bi;
  logic [1:0]  bh;
  logic [23:0] li;
  logic [13:0] bd;
  logic        aa;
  logic        lk;

  assign bo = i_br_instr[`BTC_BO_HI:`BTC_BO_LO];
  assign bi = i_br_instr[`BTC_BI_HI:`BTC_BI_LO];
  assign bh = i_br_instr[`BTC_BH_HI:`BTC_BH_LO];
  assign li = i_br_instr[`BTC_LI_HI:`BTC_LI_LO];
  assign bd = i_br_instr[`BTC_BD_HI:`BTC_BD_LO];
  assign aa = i_br_instr[`BTC_AA_BIT];
  assign lk = i_br_instr[`BTC_LK_BIT];

  // ----------------------------------------------------------------
  // target formation
  // ----------------------------------------------------------------
  logic [63:0] li_ext;
  logic [63:0] bd_ext;
  logic [63:0] tgt_raw;
  logic [63:0] tgt;
  logic [63:0] nia_raw;
  logic [63:0] nia;

  assign li_ext  = {{40{li[23]}}, li};
  assign bd_ext  = {{50{bd[13]}}, bd};
  assign nia_raw = i_br_cia + `BTC_INSN_BYTES;

  always_comb begin
    case (i_br_kind)
      BTC_K_IMM: begin
        // displacement already sits above two zero bits after the shift
        tgt_raw = aa ? (li_ext << 2) : i_br_cia + (li_ext << 2);
      end
      BTC_K_CIMM: begin
        tgt_raw = aa ? (bd_ext << 2) : i_br_cia + (bd_ext << 2);
      end
      BTC_K_LNK: begin
        tgt_raw = {st.lr[63:2], 2'b00};
      end
      BTC_K_CNT: begin
        tgt_raw = {st.ctr[63:2], 2'b00};
      end
      default: begin
        tgt_raw = nia_raw;
      end
    endcase
  end

  // clearing the top half is the very last step of formation
  assign tgt = st.mode32 ? {32'h0000_0000, tgt_raw[31:0]} : tgt_raw;
  assign nia = st.mode32 ? {32'h0000_0000, nia_raw[31:0]} : nia_raw;

  // ----------------------------------------------------------------
  // condition evaluation
  // ----------------------------------------------------------------
  logic [63:0] ctr_dec;
  logic        ctr_zero;
  logic        cr_bit;
  logic        do_dec;
  logic        ctr_ok;
  logic        cond_ok;
  logic        taken;

  // full-width decrement whatever the mode
  assign ctr_dec = st.ctr - 64'h0000_0000_0000_0001;

  btc_ctr_test #(
    .W    (64),
    .HALF (32)
  ) u_ctr_test (
    .i_value  (ctr_dec),
    .i_mode32 (st.mode32),
    .o_zero   (ctr_zero)
  );

  // condition register bits numbered from the msb
  assign cr_bit = st.cr[`BTC_CR_MSB - bi];

  // only the decode bits are looked at; hint and z bits never enter
  assign do_dec  = (i_br_kind != BTC_K_IMM) && !bo[`BTC_BO_NODEC];
  assign ctr_ok  = bo[`BTC_BO_NODEC]
                   || (bo[`BTC_BO_ZERO] ? ctr_zero : !ctr_zero);
  assign cond_ok = bo[`BTC_BO_NOCOND]
                   || (cr_bit == bo[`BTC_BO_CRVAL]);
  assign taken   = (i_br_kind == BTC_K_IMM) || (ctr_ok && cond_ok);

  // ----------------------------------------------------------------
  // hints
  // ----------------------------------------------------------------
  logic [1:0] thint;
  btc_thint_t tgt_hint;
  logic       push;

  always_comb begin
    // taken hint pair lives in different bits per code family
    if (!bo[`BTC_BO_NOCOND] && bo[`BTC_BO_NODEC]) begin
      thint = bo[`BTC_BO_ZERO:`BTC_BO_T];
    end else if (bo[`BTC_BO_NOCOND] && !bo[`BTC_BO_NODEC]) begin
      thint = {bo[`BTC_BO_CRVAL], bo[`BTC_BO_T]};
    end else begin
      thint = 2'b00;
    end
    if (i_br_kind == BTC_K_IMM) begin
      thint = 2'b00;
    end
  end

  // decoded from the target hint bits and the branch kind, never from the taken pair
  always_comb begin
    tgt_hint = BTC_TH_NONE;
    case (bh)
      2'b00: begin
        tgt_hint = (i_br_kind == BTC_K_LNK) ? BTC_TH_RETURN : BTC_TH_REPEAT;
      end
      2'b01: begin
        tgt_hint = (i_br_kind == BTC_K_LNK) ? BTC_TH_REPEAT : BTC_TH_RSVD;
      end
      2'b10: begin
        tgt_hint = BTC_TH_RSVD;
      end
      default: begin
        tgt_hint = BTC_TH_UNPRED;
      end
    endcase
    if (i_br_kind == BTC_K_IMM || i_br_kind == BTC_K_CIMM) begin
      tgt_hint = BTC_TH_NONE;
    end
  end

  // the next-address idiom would pollute the return stack
  assign push = st.stack_en && lk
                && !(i_br_kind == BTC_K_CIMM && bo == `BTC_NIA_BO
                     && bi == `BTC_NIA_BI && tgt == nia);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nx         = st;
    nx.redir   = 1'b0;
    nx.lr_push = 1'b0;
    nx.rd_data = 32'h0000_0000;
    if (i_reg_wr) begin
      case (i_reg_addr)
        `BTC_REG_CTRL: begin
          nx.mode32   = i_reg_wdata[`BTC_CTRL_MODE32];
          nx.stack_en = i_reg_wdata[`BTC_CTRL_STACK];
        end
        `BTC_REG_LR_LO:  nx.lr[31:0]   = i_reg_wdata;
        `BTC_REG_LR_HI:  nx.lr[63:32]  = i_reg_wdata;
        `BTC_REG_CTR_LO: nx.ctr[31:0]  = i_reg_wdata;
        `BTC_REG_CTR_HI: nx.ctr[63:32] = i_reg_wdata;
        `BTC_REG_CR:     nx.cr         = i_reg_wdata;
        default: begin
        end
      endcase
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        `BTC_REG_CTRL:   nx.rd_data = {30'h0, st.stack_en, st.mode32};
        `BTC_REG_LR_LO:  nx.rd_data = st.lr[31:0];
        `BTC_REG_LR_HI:  nx.rd_data = st.lr[63:32];
        `BTC_REG_CTR_LO: nx.rd_data = st.ctr[31:0];
        `BTC_REG_CTR_HI: nx.rd_data = st.ctr[63:32];
        `BTC_REG_CR:     nx.rd_data = st.cr;
        `BTC_REG_STAT:   nx.rd_data = {25'h0, st.lr_push, st.tgt_hint,
                                       st.thint, st.taken};
        default:         nx.rd_data = 32'h0000_0000;
      endcase
    end
    // branch updates come after software writes so hardware wins a clash
    if (i_br_valid) begin
      nx.redir     = 1'b1;
      nx.taken     = taken;
      nx.next_addr = taken ? tgt : nia;
      nx.thint     = thint;
      nx.tgt_hint  = tgt_hint;
      nx.lr_push   = push;
      if (do_dec) begin
        nx.ctr = ctr_dec;
      end
      if (lk) begin
        nx.lr = nia;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st           <= '0;
      st.lr        <= `BTC_RST_LR;
      st.ctr       <= `BTC_RST_CTR;
      st.cr        <= `BTC_RST_CR;
      st.tgt_hint  <= BTC_TH_NONE;
    end else begin
      st <= nx;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_reg_rdata      = st.rd_data;
  assign o_redirect_valid = st.redir;
  assign o_next_addr      = st.next_addr;
  assign o_taken          = st.taken;
  assign o_taken_hint     = st.thint;
  assign o_target_hint    = st.tgt_hint;
  assign o_lr_push        = st.lr_push;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  sequence s_req(btc_kind_t k);
    i_br_valid && !i_reg_wr && i_br_kind == k;
  endsequence

  sequence s_wide_req(btc_kind_t k);
    s_req(k) ##0 !st.mode32;
  endsequence

  property p_abs_target;
    s_wide_req(BTC_K_IMM) ##0 aa |=> o_taken && o_next_addr ==
      {{38{$past(i_br_instr[`BTC_LI_HI])}}, $past(i_br_instr[`BTC_LI_HI:`BTC_LI_LO]), 2'b00};
  endproperty
  a_abs_target: assert property (p_abs_target) else $error("absolute target wrong");

  property p_cabs_target;
    s_wide_req(BTC_K_CIMM) ##0 aa ##0 taken |=> o_taken && o_next_addr ==
      {{48{$past(i_br_instr[`BTC_BD_HI])}}, $past(i_br_instr[`BTC_BD_HI:`BTC_BD_LO]), 2'b00};
  endproperty
  a_cabs_target: assert property (p_cabs_target) else $error("cond absolute target wrong");

  property p_link_write;
    i_br_valid && !i_reg_wr && lk && !st.mode32 |=> st.lr == $past(i_br_cia) + `BTC_INSN_BYTES;
  endproperty
  a_link_write: assert property (p_link_write) else $error("link register not updated");

  property p_lnk_target;
    s_wide_req(BTC_K_LNK) ##0 taken |=> o_redirect_valid
      && o_next_addr == {$past(st.lr[63:2]), 2'b00};
  endproperty
  a_lnk_target: assert property (p_lnk_target) else $error("link target wrong");

  property p_lnk_untaken;
    s_wide_req(BTC_K_CNT) ##0 lk ##0 !taken
      |=> !o_taken && st.lr == $past(i_br_cia) + `BTC_INSN_BYTES;
  endproperty
  a_lnk_untaken: assert property (p_lnk_untaken) else $error("link skipped when untaken");

  property p_ctr_dec;
    i_br_valid && !i_reg_wr && i_br_kind != BTC_K_IMM && !bo[`BTC_BO_NODEC]
      |=> st.ctr == $past(st.ctr) - 64'h1;
  endproperty
  a_ctr_dec: assert property (p_ctr_dec) else $error("count not decremented");

  property p_ctr_hold;
    i_br_valid && !i_reg_wr && bo[`BTC_BO_NODEC] |=> $stable(st.ctr);
  endproperty
  a_ctr_hold: assert property (p_ctr_hold) else $error("count touched");

  property p_always;
    i_br_valid && i_br_kind != BTC_K_IMM && bo[`BTC_BO_NOCOND] && bo[`BTC_BO_NODEC]
      |=> o_redirect_valid && o_taken;
  endproperty
  a_always: assert property (p_always) else $error("branch-always not taken");

  property p_narrow;
    i_br_valid && st.mode32 && !i_reg_wr |=> o_next_addr[63:32] == 32'h0;
  endproperty
  a_narrow: assert property (p_narrow) else $error("upper target bits not cleared");

  property p_seq;
    i_br_valid && !taken |=> !o_taken ##0 o_next_addr[31:0] == $past(nia_raw[31:0]);
  endproperty
  a_seq: assert property (p_seq) else $error("untaken branch not sequential");

  property p_nia_nopush;
    i_br_valid && i_br_kind == BTC_K_CIMM && bo == `BTC_NIA_BO && bi == `BTC_NIA_BI
      && !aa && bd == 14'h1 |=> !o_lr_push;
  endproperty
  a_nia_nopush: assert property (p_nia_nopush) else $error("next-address form pushed");

endmodule : btc_unit

// ===== tb/btc_fetch_model.sv
// fetch-side stand-in that issues branch requests and records redirects
`timescale 1ns/1ps
module btc_fetch_model (
  // clock
  input  wire logic              i_clk_sys,
  // outcome from the unit
  input  wire logic              i_redirect_valid,
  input  wire logic [63:0]       i_next_addr,
  // request to the unit
  output logic                   o_br_valid,
  output btc_pkg::btc_kind_t     o_br_kind,
  output logic [31:0]            o_br_instr,
  output logic [63:0]            o_br_cia
);
  import btc_pkg::*;
  logic        seen;
  logic [63:0] addr;

  initial begin
    o_br_valid = 1'b0;
    o_br_kind  = BTC_K_IMM;
    o_br_instr = 32'h0;
    o_br_cia   = 64'h0;
  end

  // one request, held for the taking edge only
  // hint pair stays 00 except where a scenario exercises its decode
  task automatic issue(input btc_kind_t k, input logic [31:0] ins, input logic [63:0] cia);
    @(posedge i_clk_sys);
    o_br_valid <= 1'b1;
    o_br_kind  <= k;
    o_br_instr <= ins;
    o_br_cia   <= cia;
    @(posedge i_clk_sys);
    o_br_valid <= 1'b0;
    // released lines carry junk so nothing leans on stale values
    o_br_instr <= ~ins;
    o_br_cia   <= ~cia;
    #1;
    seen = i_redirect_valid;
    addr = i_next_addr;
  endtask : issue
endmodule : btc_fetch_model

// ===== tb/btc_unit_test.sv
// self-checking bench for the branch target and condition unit
`timescale 1ns/1ps
module btc_unit_test;
  import btc_pkg::*;
  logic              clk;
  logic              rst;
  logic              rd;
  logic              wr;
  logic [7:0]        a;
  logic [31:0]       wd;
  logic [31:0]       rdata;
  logic              redir;
  logic              bv;
  btc_kind_t         bk;
  logic [31:0]       bi;
  logic [63:0]       bc;
  logic [63:0]       nxt;
  logic              tkn;
  logic [1:0]        thint;
  btc_thint_t        tgt;
  logic              push;
  int                num_errors;
  int                n_compared;
  logic [10:0]       tbl [14] = '{
    11'b10000_00000_1, 11'b10010_00000_1, 11'b10000_00000_1, 11'b01000_11111_1,
    11'b01001_11111_1, 11'b01010_11111_0, 11'b00000_11110_1, 11'b00010_11110_0,
    11'b01100_11111_1, 11'b01100_11110_0, 11'b00100_11110_1, 11'b00100_11111_0,
    11'b11111_00000_1, 11'b10100_00000_1};
  btc_thint_t        th_lnk [4] = '{BTC_TH_RETURN, BTC_TH_REPEAT, BTC_TH_RSVD, BTC_TH_UNPRED};
  btc_thint_t        th_cnt [4] = '{BTC_TH_REPEAT, BTC_TH_RSVD, BTC_TH_RSVD, BTC_TH_UNPRED};

  always #5 clk = ~clk;

  btc_unit u_btc_unit (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_br_valid(bv), .i_br_kind(bk), .i_br_instr(bi),
    .i_br_cia(bc), .i_reg_addr(a), .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .o_redirect_valid(redir), .o_next_addr(nxt), .o_taken(tkn),
    .o_taken_hint(thint), .o_target_hint(tgt), .o_lr_push(push)
  );

  btc_fetch_model u_btc_fetch_model (
    .i_clk_sys(clk), .i_redirect_valid(redir), .i_next_addr(nxt),
    .o_br_valid(bv), .o_br_kind(bk), .o_br_instr(bi), .o_br_cia(bc)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] ins(input logic [4:0] bo, input logic [4:0] sel,
                                      input logic [15:0] lo);
    return {6'h10, bo, sel, lo};
  endfunction : ins

  function automatic logic [31:0] li(input logic [23:0] d, input logic aa, input logic lk);
    return {6'h12, d, aa, lk};
  endfunction : li

  task automatic test_done;
    if (num_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic reg_wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    a  <= ad;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] ad, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    a  <= ad;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", ad), {32'h0, e}, {32'h0, rdata});
  endtask : reg_rd

  task automatic br(input btc_kind_t k, input logic [31:0] i, input logic [63:0] cia,
                    input logic t, input logic [63:0] e);
    u_btc_fetch_model.issue(k, i, cia);
    chk("redirect", 64'h1, {63'h0, u_btc_fetch_model.seen});
    chk("taken", {63'h0, t}, {63'h0, tkn});
    chk("next", e, u_btc_fetch_model.addr);
  endtask : br

  // ----------------------------------------------------------------
  // watchdog: whole run is well under a thousand cycles
  // ----------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    test_done();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    a = 8'h0;
    wd = 32'h0;
    num_errors = 0;
    n_compared = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    reg_rd(8'h00, 32'h0);
    reg_wr(8'h40, 32'h5);
    reg_rd(8'h40, 32'h0);
    reg_wr(8'h14, 32'h1);
    br(BTC_K_IMM, li(24'h800001, 1, 0), 64'h1000, 1, 64'hffff_ffff_fe00_0004);
    br(BTC_K_IMM, li(24'h2, 0, 1), 64'h2000, 1, 64'h2008);
    reg_rd(8'h04, 32'h2004);
    br(BTC_K_CIMM, ins(5'h14, 5'h0, 16'h8002), 64'h3000, 1, 64'hffff_ffff_ffff_8000);
    // condition table walks the count down from 2 across zero
    reg_wr(8'h10, 32'h0);
    reg_wr(8'h0c, 32'h2);
    foreach (tbl[n]) begin
      br(BTC_K_CIMM, ins(tbl[n][10:6], tbl[n][5:1], 16'h0012), 64'h800, tbl[n][0],
         tbl[n][0] ? 64'h10 : 64'h804);
    end
    reg_rd(8'h0c, 32'hffff_fffa);
    reg_rd(8'h10, 32'hffff_ffff);
    reg_wr(8'h0c, 32'h1);
    reg_wr(8'h10, 32'h5);
    br(BTC_K_CIMM, ins(5'h12, 5'h0, 16'h0012), 64'h800, 0, 64'h804);
    reg_wr(8'h00, 32'h1);
    reg_wr(8'h0c, 32'h1);
    br(BTC_K_CIMM, ins(5'h12, 5'h0, 16'h0012), 64'h800, 1, 64'h10);
    br(BTC_K_IMM, li(24'h800001, 1, 0), 64'h1000, 1, 64'hfe00_0004);
    reg_wr(8'h00, 32'h0);
    reg_wr(8'h04, 32'h3007);
    br(BTC_K_LNK, ins(5'h14, 5'h0, 16'h0001), 64'h500, 1, 64'h3004);
    reg_rd(8'h04, 32'h504);
    reg_wr(8'h0c, 32'h4003);
    reg_wr(8'h10, 32'h0);
    br(BTC_K_CNT, ins(5'h14, 5'h0, 16'h0000), 64'h500, 1, 64'h4000);
    br(BTC_K_CNT, ins(5'h0c, 5'd30, 16'h0001), 64'h600, 0, 64'h604);
    reg_rd(8'h04, 32'h604);
    for (int h = 0; h < 4; h++) begin
      br(BTC_K_LNK, ins(5'h14, 5'h0, 16'(h << 11)), 64'h900, 1, 64'h604);
      chk("lnk hint", 64'(th_lnk[h]), 64'(tgt));
      br(BTC_K_CNT, ins(5'h14, 5'h0, 16'(h << 11)), 64'h900, 1, 64'h4000);
      chk("cnt hint", 64'(th_cnt[h]), 64'(tgt));
      br(BTC_K_CIMM, ins({3'b001, 2'(h)}, 5'd31, 16'h0012), 64'h900, 0, 64'h904);
      chk("at", 64'(h), 64'(thint));
      chk("cimm hint", 64'(BTC_TH_NONE), 64'(tgt));
    end
    br(BTC_K_CIMM, ins(5'h19, 5'h0, 16'h0012), 64'h900, 1, 64'h10);
    chk("at", 64'h3, 64'(thint));
    reg_wr(8'h00, 32'h2);
    br(BTC_K_IMM, li(24'h1, 0, 1), 64'ha00, 1, 64'ha04);
    chk("push", 64'h1, 64'(push));
    br(BTC_K_CIMM, ins(5'h14, 5'd31, 16'h0005), 64'ha00, 1, 64'ha04);
    chk("push", 64'h0, 64'(push));
    // status of the last branch: taken, no hints, no push
    reg_rd(8'h18, 32'h0000_0001);
    reg_wr(8'h08, 32'h0000_00a5);
    reg_rd(8'h08, 32'h0000_00a5);
    test_done();
  end
endmodule : btc_unit_test
